/* File: rtl/pes_counter.sv */
/*
  One performance counter with its event selection and filtering.
  Assumes every event input comes from logic on clk: occurrences are one-cycle
  pulses, cycle events are levels, and the version field is held steady.
*/
// Overview of operation
// (RULE1) Architectural additions only when major version is 2
// (RULE2) Queue 0x40 counts dropped queue writes, queue filter
// (RULE3) Engine 0x40 counts allowed permission-table bitmap reads
// (RULE4) Engine 0x80 counts denied permission-table bitmap reads
// (RULE5) Engine 0x100 adds data read in 32-byte units
// (RULE6) Engine 0x200 counts second source reads
// (RULE7) Engine 0x400 counts second destination writes
// (RULE8) Ops 0x20000 counts translation fetch descriptors
// (RULE9) Ops 0x40000 counts integrity generate descriptors
// (RULE10) Ops2 0x1 counts cross-space copy descriptors
// (RULE11) Ops2 0x2 fill, 0x4 compare descriptors
// (RULE12) Ops2 0x8 counts cross-space pattern descriptors
// (RULE13) Ops2 0x400 counts window update descriptors
// (RULE14) Model-specific events only when major version is 1
// (RULE15) Queue 0x40/0x80 single/group ready cycles
// (RULE16) Queue 0x100 counts cycles any selected queue empty
// (RULE17) Engine 0x40 counts pipeline-full stall cycles
// (RULE18) Engine 0x80 counts nothing-ready cycles
// (RULE19) Engine 0x100 counts group fetch full cycles
// (RULE20) Engine 0x200 counts group exec full cycles
// (RULE21) Count per occurrence or cycle, filters matching
// (RULE22) Encodings are one-hot, several combine per counter
`timescale 1ns/1ps

module pes_counter #(
  parameter int CW = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Configuration
  input wire logic [3:0] version_major,
  input wire pes_pkg::pes_cfg_t cfg,
  input wire pes_pkg::pes_filter_t filt,
  input wire logic count_clear,
  // Occurrence events
  input wire pes_pkg::pes_desc_t queue_write_dropped,
  input wire pes_pkg::pes_desc_t perm_bitmap_read,
  input wire logic perm_allowed,
  input wire pes_pkg::pes_desc_t data_read,
  input wire logic [3:0] bytes_read_32b_units,
  input wire pes_pkg::pes_desc_t second_source_reads,
  input wire pes_pkg::pes_desc_t second_dest_writes,
  input wire pes_pkg::pes_desc_t op_done,
  input wire pes_pkg::pes_op_t op_kind,
  // Cycle events
  input wire logic [pes_pkg::NWQ-1:0] single_desc_ready,
  input wire logic [pes_pkg::NWQ-1:0] group_desc_ready,
  input wire logic [pes_pkg::NWQ-1:0] queue_empty,
  input wire logic [pes_pkg::NENG-1:0] pipe_full,
  input wire logic [pes_pkg::NENG-1:0] nothing_ready,
  input wire logic [pes_pkg::NENG-1:0] group_fetch_full,
  input wire logic [pes_pkg::NENG-1:0] group_exec_full,
  // Result
  output logic [CW-1:0] count
);

  ////////////////////////////////////////////////////////////////////////////
  // Filter matching

  // True when the occurrence is valid and every used filter accepts it
  function automatic logic pass(input pes_pkg::pes_desc_t d, input pes_pkg::pes_filter_t f,
                                input logic [4:0] use_m);
    logic ok;
    ok = d.valid;
    ok = ok & (!use_m[4] | f.queue_mask[d.queue_id]);
    ok = ok & (!use_m[3] | f.eng_mask[d.eng]);
    ok = ok & (!use_m[2] | !f.pasid_en | (f.pasid == d.pasid));
    ok = ok & (!use_m[1] | f.tc_mask[d.tc]);
    ok = ok & (!use_m[0] | f.size_mask[d.size_cls]);
    return ok;
  endfunction : pass

  ////////////////////////////////////////////////////////////////////////////
  // Selection decode

  // Version gates for the two event groups
  wire arch_on = (version_major == pes_pkg::VER_ARCH_ADD); // [RULE1]
  wire model_on = (version_major == pes_pkg::VER_MODEL_1); // [RULE14]

  // Category enables
  wire cat_q = cfg.enable & (cfg.category == pes_pkg::CAT_QUEUE);
  wire cat_e = cfg.enable & (cfg.category == pes_pkg::CAT_ENGINE);
  wire cat_o = cfg.enable & (cfg.category == pes_pkg::CAT_OPS);
  wire cat_o2 = cfg.enable & (cfg.category == pes_pkg::CAT_OPS2);

  // Each encoding is tested as its own bit
  wire s_drop = |(cfg.sel & pes_pkg::SEL_QUEUE_WRITE_DROPPED); // [RULE22]
  wire s_pok = |(cfg.sel & pes_pkg::SEL_PERM_READ_ALLOWED);
  wire s_pno = |(cfg.sel & pes_pkg::SEL_PERM_READ_DENIED);
  wire s_rd = |(cfg.sel & pes_pkg::SEL_BYTES_READ_32B);
  wire s_src2 = |(cfg.sel & pes_pkg::SEL_SECOND_SOURCE);
  wire s_dst2 = |(cfg.sel & pes_pkg::SEL_SECOND_DEST);
  wire s_tf = |(cfg.sel & pes_pkg::SEL_TRANSLATION_FETCH);
  wire s_ig = |(cfg.sel & pes_pkg::SEL_INTEGRITY_GEN);
  wire s_xc = |(cfg.sel & pes_pkg::SEL_XSPACE_COPY);
  wire s_xf = |(cfg.sel & pes_pkg::SEL_XSPACE_FILL);
  wire s_xm = |(cfg.sel & pes_pkg::SEL_XSPACE_COMPARE);
  wire s_xp = |(cfg.sel & pes_pkg::SEL_XSPACE_PATTERN);
  wire s_wu = |(cfg.sel & pes_pkg::SEL_WINDOW_UPDATE);
  wire s_sr = |(cfg.sel & pes_pkg::SEL_SINGLE_READY_CYC);
  wire s_gr = |(cfg.sel & pes_pkg::SEL_GROUP_READY_CYC);
  wire s_qe = |(cfg.sel & pes_pkg::SEL_QUEUE_EMPTY_CYC);
  wire s_pf = |(cfg.sel & pes_pkg::SEL_PIPE_FULL_CYC);
  wire s_nr = |(cfg.sel & pes_pkg::SEL_NOTHING_READY_CYC);
  wire s_ff = |(cfg.sel & pes_pkg::SEL_FETCH_FULL_CYC);
  wire s_ef = |(cfg.sel & pes_pkg::SEL_EXEC_FULL_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Architectural occurrence hits

  // Group of checks shared by queue, engine and operation events
  wire arch_q = arch_on & cat_q;
  wire arch_e = arch_on & cat_e;
  wire arch_o = arch_on & cat_o;
  wire arch_o2 = arch_on & cat_o2;
  wire perm_ok = pass(perm_bitmap_read, filt, pes_pkg::USE_E | pes_pkg::USE_P);
  wire op_ok = pass(op_done, filt, pes_pkg::USE_Q | pes_pkg::USE_P);
  wire op2_ok = pass(op_done, filt, pes_pkg::USE_QSP);

  wire h_drop = arch_q & s_drop & pass(queue_write_dropped, filt, pes_pkg::USE_Q); // [RULE2]
  wire h_pok = arch_e & s_pok & perm_ok & perm_allowed; // [RULE3]
  wire h_pno = arch_e & s_pno & perm_ok & !perm_allowed; // [RULE4]
  wire h_rd = arch_e & s_rd & pass(data_read, filt, pes_pkg::USE_E); // [RULE5]
  wire h_src2 = arch_e & s_src2 & pass(second_source_reads, filt, pes_pkg::USE_TSE); // [RULE6]
  wire h_dst2 = arch_e & s_dst2 & pass(second_dest_writes, filt, pes_pkg::USE_TSE); // [RULE7]
  wire h_tf = arch_o & s_tf & op_ok & (op_kind == pes_pkg::PES_OP_TRANS_FETCH); // [RULE8]
  wire h_ig = arch_o & s_ig & op_ok & (op_kind == pes_pkg::PES_OP_INTEG_GEN); // [RULE9]
  wire h_xc = arch_o2 & s_xc & op2_ok & (op_kind == pes_pkg::PES_OP_XS_COPY); // [RULE10]
  wire h_xf = arch_o2 & s_xf & op2_ok & (op_kind == pes_pkg::PES_OP_XS_FILL); // [RULE11]
  wire h_xm = arch_o2 & s_xm & op2_ok & (op_kind == pes_pkg::PES_OP_XS_COMPARE); // [RULE11]
  wire h_xp = arch_o2 & s_xp & op2_ok & (op_kind == pes_pkg::PES_OP_XS_PATTERN); // [RULE12]
  wire h_wu = arch_o2 & s_wu & op2_ok & (op_kind == pes_pkg::PES_OP_WIN_UPDATE); // [RULE13]

  ////////////////////////////////////////////////////////////////////////////
  // Model-specific cycle hits

  // A cycle counts once when any selected queue or engine qualifies
  wire ms_q = model_on & cat_q;
  wire ms_e = model_on & cat_e;
  wire h_sr = ms_q & s_sr & |(single_desc_ready & filt.queue_mask); // [RULE15]
  wire h_gr = ms_q & s_gr & |(group_desc_ready & filt.queue_mask); // [RULE15]
  wire h_qe = ms_q & s_qe & |(queue_empty & filt.queue_mask); // [RULE16]
  wire h_pf = ms_e & s_pf & |(pipe_full & filt.eng_mask); // [RULE17]
  wire h_nr = ms_e & s_nr & |(nothing_ready & filt.eng_mask); // [RULE18]
  wire h_ff = ms_e & s_ff & |(group_fetch_full & filt.eng_mask); // [RULE19]
  wire h_ef = ms_e & s_ef & |(group_exec_full & filt.eng_mask); // [RULE20]

  ////////////////////////////////////////////////////////////////////////////
  // Increment and counter

  // Sum of all single-step hits this cycle
  wire [4:0] ones = 5'(h_drop) + 5'(h_pok) + 5'(h_pno) + 5'(h_src2) + 5'(h_dst2)
                  + 5'(h_tf) + 5'(h_ig) + 5'(h_xc) + 5'(h_xf) + 5'(h_xm) + 5'(h_xp)
                  + 5'(h_wu) + 5'(h_sr) + 5'(h_gr) + 5'(h_qe) + 5'(h_pf) + 5'(h_nr)
                  + 5'(h_ff) + 5'(h_ef); // [RULE22]
  // Data read adds its unit count instead of one
  wire [4:0] rd_add = h_rd ? 5'(bytes_read_32b_units) : 5'h00; // [RULE5]
  wire [5:0] inc = 6'(ones) + 6'(rd_add); // [RULE21]

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  // A clear keeps the events of its own cycle
  assign count_next = count_clear ? CW'(inc) : count_reg + CW'(inc); // [RULE21]
  assign count = count_reg;

  // Counter register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= CW'(pes_pkg::CNT_RST);
    end else begin
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Dropped write seen through the queue filter
  sequence drop_seen_s;
    arch_on && cat_q && s_drop && queue_write_dropped.valid && filt.queue_mask[queue_write_dropped.queue_id];
  endsequence

  // Counter moves by the hits of the cycle before
  sequence plain_step_s;
    !count_clear && arst_n ##1 1'b1;
  endsequence

  arch_gate_a: assert property (!arch_on |-> !(h_drop || h_pok || h_pno || h_rd || h_tf || h_wu)) // [RULE1]
    else $error("architectural event counted on wrong version");
  drop_count_a: assert property (drop_seen_s |-> h_drop && inc >= 6'h01) // [RULE2]
    else $error("dropped queue write not counted");
  perm_ok_a: assert property (h_pok |-> perm_allowed && perm_bitmap_read.valid && filt.eng_mask[perm_bitmap_read.eng]) // [RULE3]
    else $error("allowed bitmap read counted without cause");
  perm_denied_a: assert property (h_pno |-> !perm_allowed && !h_pok) // [RULE4]
    else $error("denied bitmap read counted wrongly");
  model_gate_a: assert property (!model_on |-> !(h_sr || h_gr || h_qe || h_pf || h_nr || h_ff || h_ef)) // [RULE14]
    else $error("model event counted on wrong version");
  empty_cycle_a: assert property (model_on && cat_q && s_qe && |(queue_empty & filt.queue_mask) |-> h_qe) // [RULE16]
    else $error("empty queue cycle missed");
  pipe_full_a: assert property (h_pf |-> pipe_full != 4'h0 && cfg.category == pes_pkg::CAT_ENGINE) // [RULE17]
    else $error("pipe full cycle counted without cause");
  count_step_a: assert property (plain_step_s |-> count_reg == $past(count_reg) + CW'($past(inc))) // [RULE21]
    else $error("counter did not add the cycle increment");
  clear_keep_a: assert property (count_clear && arst_n |=> count_reg == CW'($past(inc))) // [RULE21]
    else $error("clear lost the events of its cycle");
  onehot_mix_a: assert property (h_sr && h_qe |-> inc >= 6'h02) // [RULE22]
    else $error("combined selections not summed");

  // Data read seen through the engine filter
  sequence read_seen_s;
    arch_on && cat_e && s_rd && data_read.valid && filt.eng_mask[data_read.eng];
  endsequence

  // Inter-domain operation seen through queue, size and id filters
  sequence op2_seen_s;
    arch_on && cat_o2 && op_done.valid && filt.queue_mask[op_done.queue_id]
      && filt.size_mask[op_done.size_cls] && (!filt.pasid_en || filt.pasid == op_done.pasid);
  endsequence

  // Other version values unlock nothing
  ver_other_a: assert property (!arch_on && !model_on |-> inc == 6'h00) // [RULE1]
    else $error("unknown version counted");

  // Data read adds its unit count, not one
  read_units_a: assert property (read_seen_s |-> h_rd && rd_add == 5'(bytes_read_32b_units)) // [RULE5]
    else $error("read units lost");

  // Second operand counts pass class, size and engine filters
  src2_filter_a: assert property (h_src2 |-> // [RULE6]
    filt.tc_mask[second_source_reads.tc] && filt.size_mask[second_source_reads.size_cls]
    && filt.eng_mask[second_source_reads.eng])
    else $error("second source filter open");
  dst2_filter_a: assert property (h_dst2 |-> // [RULE7]
    filt.tc_mask[second_dest_writes.tc] && filt.size_mask[second_dest_writes.size_cls]
    && filt.eng_mask[second_dest_writes.eng])
    else $error("second dest filter open");

  // Operation counts need the matching kind and filters
  fetch_op_a: assert property (h_tf |-> // [RULE8]
    op_kind == pes_pkg::PES_OP_TRANS_FETCH && filt.queue_mask[op_done.queue_id])
    else $error("fetch op without cause");
  integ_op_a: assert property (h_ig |-> // [RULE9]
    op_kind == pes_pkg::PES_OP_INTEG_GEN && (!filt.pasid_en || filt.pasid == op_done.pasid))
    else $error("generate op without cause");

  // Each inter-domain kind counts on its own bit
  copy_count_a: assert property (op2_seen_s ##0 (s_xc && op_kind == pes_pkg::PES_OP_XS_COPY) // [RULE10]
    |-> h_xc)
    else $error("copy op missed");
  fill_count_a: assert property (op2_seen_s ##0 (s_xf && op_kind == pes_pkg::PES_OP_XS_FILL) // [RULE11]
    |-> h_xf)
    else $error("fill op missed");
  compare_count_a: assert property (op2_seen_s ##0 (s_xm && op_kind == pes_pkg::PES_OP_XS_COMPARE) // [RULE11]
    |-> h_xm)
    else $error("compare op missed");
  pattern_count_a: assert property (op2_seen_s ##0 (s_xp && op_kind == pes_pkg::PES_OP_XS_PATTERN) // [RULE12]
    |-> h_xp)
    else $error("pattern op missed");
  window_count_a: assert property (op2_seen_s ##0 (s_wu && op_kind == pes_pkg::PES_OP_WIN_UPDATE) // [RULE13]
    |-> h_wu)
    else $error("window op missed");

  // Transfer size gates every inter-domain count
  op2_size_a: assert property (h_xc || h_xf || h_xm || h_xp || h_wu |-> // [RULE10]
    filt.size_mask[op_done.size_cls])
    else $error("size filter open");

  // Model cycles count once when a masked queue or engine qualifies
  single_ready_a: assert property (h_sr |-> |(single_desc_ready & filt.queue_mask)) // [RULE15]
    else $error("ready cycle without cause");
  group_ready_a: assert property (model_on && cat_q && s_gr && |(group_desc_ready & filt.queue_mask) // [RULE15]
    |-> h_gr)
    else $error("group ready cycle missed");

  empty_cause_a: assert property (h_qe |-> |(queue_empty & filt.queue_mask)) // [RULE16]
    else $error("empty cycle without cause");

  pipe_count_a: assert property (model_on && cat_e && s_pf && |(pipe_full & filt.eng_mask) // [RULE17]
    |-> h_pf)
    else $error("pipe full cycle missed");

  nothing_ready_a: assert property (h_nr |-> |(nothing_ready & filt.eng_mask)) // [RULE18]
    else $error("idle cycle without cause");

  fetch_full_a: assert property (model_on && cat_e && s_ff && |(group_fetch_full & filt.eng_mask) // [RULE19]
    |-> h_ff)
    else $error("fetch full cycle missed");

  exec_full_a: assert property (h_ef |-> |(group_exec_full & filt.eng_mask)) // [RULE20]
    else $error("exec full without cause");

  // A disabled counter or an empty selection adds nothing
  off_idle_a: assert property (!cfg.enable |-> inc == 6'h00) // [RULE21]
    else $error("disabled counter moved");

  sel_none_a: assert property (cfg.sel == 32'h0000_0000 |-> inc == 6'h00) // [RULE22]
    else $error("empty selection counted");

endmodule : pes_counter

/* File: rtl/pes_pkg.sv */
/*
  Shared constants and types for the performance event selector: category
  numbers, one-hot event encodings, filter-use masks and the event carriers.
  Assumes one device clock for all producers of events.
*/
package pes_pkg;

  // Sizes of the attribute fields
  localparam int NWQ = 8;
  localparam int NENG = 4;
  localparam int PW = 20;

  // Major version values that unlock event groups
  localparam logic [3:0] VER_ARCH_ADD = 4'h2;
  localparam logic [3:0] VER_MODEL_1 = 4'h1;

  // Category numbers
  localparam logic [2:0] CAT_QUEUE = 3'h0;
  localparam logic [2:0] CAT_ENGINE = 3'h1;
  localparam logic [2:0] CAT_OPS = 3'h3;
  localparam logic [2:0] CAT_OPS2 = 3'h5;

  // Architectural additions, queue and engine categories
  localparam logic [31:0] SEL_QUEUE_WRITE_DROPPED = 32'h0000_0040;
  localparam logic [31:0] SEL_PERM_READ_ALLOWED = 32'h0000_0040;
  localparam logic [31:0] SEL_PERM_READ_DENIED = 32'h0000_0080;
  localparam logic [31:0] SEL_BYTES_READ_32B = 32'h0000_0100;
  localparam logic [31:0] SEL_SECOND_SOURCE = 32'h0000_0200;
  localparam logic [31:0] SEL_SECOND_DEST = 32'h0000_0400;
  // Architectural additions, operation categories
  localparam logic [31:0] SEL_TRANSLATION_FETCH = 32'h0002_0000;
  localparam logic [31:0] SEL_INTEGRITY_GEN = 32'h0004_0000;
  localparam logic [31:0] SEL_XSPACE_COPY = 32'h0000_0001;
  localparam logic [31:0] SEL_XSPACE_FILL = 32'h0000_0002;
  localparam logic [31:0] SEL_XSPACE_COMPARE = 32'h0000_0004;
  localparam logic [31:0] SEL_XSPACE_PATTERN = 32'h0000_0008;
  localparam logic [31:0] SEL_WINDOW_UPDATE = 32'h0000_0400;
  // Model-specific cycle events, version 1
  localparam logic [31:0] SEL_SINGLE_READY_CYC = 32'h0000_0040;
  localparam logic [31:0] SEL_GROUP_READY_CYC = 32'h0000_0080;
  localparam logic [31:0] SEL_QUEUE_EMPTY_CYC = 32'h0000_0100;
  localparam logic [31:0] SEL_PIPE_FULL_CYC = 32'h0000_0040;
  localparam logic [31:0] SEL_NOTHING_READY_CYC = 32'h0000_0080;
  localparam logic [31:0] SEL_FETCH_FULL_CYC = 32'h0000_0100;
  localparam logic [31:0] SEL_EXEC_FULL_CYC = 32'h0000_0200;

  // Filter-use masks {queue, engine, space id, class, size}
  localparam logic [4:0] USE_Q = 5'h10;
  localparam logic [4:0] USE_E = 5'h08;
  localparam logic [4:0] USE_P = 5'h04;
  localparam logic [4:0] USE_TSE = 5'h0B;
  localparam logic [4:0] USE_QSP = 5'h15;

  // Counter value after reset
  localparam logic [31:0] CNT_RST = 32'h0000_0000;

  // Kinds of finished operation descriptors
  typedef enum logic [2:0] {
    PES_OP_TRANS_FETCH = 3'b000,
    PES_OP_INTEG_GEN = 3'b001,
    PES_OP_XS_COPY = 3'b010,
    PES_OP_XS_FILL = 3'b011,
    PES_OP_XS_COMPARE = 3'b100,
    PES_OP_XS_PATTERN = 3'b101,
    PES_OP_WIN_UPDATE = 3'b110,
    PES_OP_OTHER = 3'b111
  } pes_op_t;

  // One occurrence with its filterable attributes
  typedef struct packed {
    logic valid;
    logic [2:0] queue_id;
    logic [1:0] eng;
    logic [PW-1:0] pasid;
    logic [2:0] tc;
    logic [1:0] size_cls;
  } pes_desc_t;

  // Filter settings for one counter
  typedef struct packed {
    logic [NWQ-1:0] queue_mask;
    logic [NENG-1:0] eng_mask;
    logic pasid_en;
    logic [PW-1:0] pasid;
    logic [7:0] tc_mask;
    logic [3:0] size_mask;
  } pes_filter_t;

  // Counter selection
  typedef struct packed {
    logic enable;
    logic [2:0] category;
    logic [31:0] sel;
  } pes_cfg_t;

endpackage : pes_pkg

/* File: tb/tb_perf_event_selector.sv */
/*
  Self-checking bench for pes_counter: a table of single- and mixed-event cases, then
  held cycle events, bursts, clear with a hit, the id filter switch and reset.
  Assumes one 50 MHz clock and the event carriers of pes_pkg.
*/
`timescale 1ns/1ps

module tb_perf_event_selector;
  ////////////////////////////////////////////////////////////////////////////
  // One table row: settings, event mask, attributes, expected count
  typedef struct packed {
    logic [3:0] ver;
    logic en;
    logic [2:0] cat;
    logic [31:0] sel;
    logic [12:0] ev; // Drop,perm,data,src2,dst2,op,single,group,empty,pipe,none,fetch,exec
    logic [2:0] kind;
    logic allow;
    logic [3:0] units;
    logic [7:0] bv; // Queue or engine levels
    pes_pkg::pes_desc_t d;
    logic [7:0] exp;
  } pes_row_t;

  // Attributes that pass the filter, and variants that each miss one field
  localparam pes_pkg::pes_desc_t dm = '{1'b0, 3'h3, 2'h1, 20'h0_0abc, 3'h2, 2'h1};
  localparam pes_pkg::pes_desc_t dm_q = '{1'b0, 3'h2, 2'h1, 20'h0_0abc, 3'h2, 2'h1};
  localparam pes_pkg::pes_desc_t dm_id = '{1'b0, 3'h3, 2'h1, 20'h0_0abd, 3'h2, 2'h1};
  localparam pes_pkg::pes_desc_t dm_eng = '{1'b0, 3'h3, 2'h0, 20'h0_0abc, 3'h2, 2'h1};
  localparam pes_pkg::pes_desc_t dm_tc = '{1'b0, 3'h3, 2'h1, 20'h0_0abc, 3'h1, 2'h1};
  localparam pes_pkg::pes_desc_t dm_sz = '{1'b0, 3'h3, 2'h1, 20'h0_0abc, 3'h2, 2'h0};

  // Design ports
  logic clk;
  logic arst_n;
  logic [3:0] version_major;
  pes_pkg::pes_cfg_t cfg;
  pes_pkg::pes_filter_t filt;
  logic count_clear;
  pes_pkg::pes_desc_t qwd, pbr, drd, s2r, d2w, opd;
  logic perm_allowed;
  logic [3:0] units;
  pes_pkg::pes_op_t op_kind;
  logic [7:0] sdr, gdr, qem;
  logic [3:0] pfl, nrd, gff, gef;
  logic [31:0] count;
  // Bookkeeping
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  pes_row_t rows [$] = '{
    '{4'h2,1'b1,3'h0,32'h0000_0040,13'h0001,3'h7,1'b1,4'h1,8'h00,dm,8'h01},
    '{4'h2,1'b1,3'h0,32'h0000_0040,13'h0001,3'h7,1'b1,4'h1,8'h00,dm_q,8'h00},
    '{4'h1,1'b1,3'h0,32'h0000_0040,13'h0001,3'h7,1'b1,4'h1,8'h00,dm,8'h00},
    '{4'h3,1'b1,3'h0,32'h0000_0040,13'h0001,3'h7,1'b1,4'h1,8'h00,dm,8'h00},
    '{4'h2,1'b0,3'h0,32'h0000_0040,13'h0001,3'h7,1'b1,4'h1,8'h00,dm,8'h00},
    '{4'h2,1'b1,3'h0,32'h0000_0040,13'h0002,3'h7,1'b1,4'h1,8'h00,dm,8'h00},
    '{4'h2,1'b1,3'h1,32'h0000_0040,13'h0002,3'h7,1'b1,4'h1,8'h00,dm,8'h01},
    '{4'h2,1'b1,3'h1,32'h0000_0040,13'h0002,3'h7,1'b0,4'h1,8'h00,dm,8'h00},
    '{4'h2,1'b1,3'h1,32'h0000_0080,13'h0002,3'h7,1'b0,4'h1,8'h00,dm,8'h01},
    '{4'h2,1'b1,3'h1,32'h0000_0080,13'h0002,3'h7,1'b0,4'h1,8'h00,dm_id,8'h00},
    '{4'h2,1'b1,3'h1,32'h0000_0100,13'h0004,3'h7,1'b1,4'hf,8'h00,dm,8'h0f},
    '{4'h2,1'b1,3'h1,32'h0000_0100,13'h0004,3'h7,1'b1,4'h5,8'h00,dm_eng,8'h00},
    '{4'h2,1'b1,3'h1,32'h0000_0200,13'h0008,3'h7,1'b1,4'h1,8'h00,dm,8'h01},
    '{4'h2,1'b1,3'h1,32'h0000_0200,13'h0008,3'h7,1'b1,4'h1,8'h00,dm_tc,8'h00},
    '{4'h2,1'b1,3'h1,32'h0000_0400,13'h0010,3'h7,1'b1,4'h1,8'h00,dm,8'h01},
    '{4'h2,1'b1,3'h1,32'h0000_0400,13'h0010,3'h7,1'b1,4'h1,8'h00,dm_sz,8'h00},
    '{4'h2,1'b1,3'h3,32'h0002_0000,13'h0020,3'h0,1'b1,4'h1,8'h00,dm,8'h01},
    '{4'h2,1'b1,3'h3,32'h0004_0000,13'h0020,3'h1,1'b1,4'h1,8'h00,dm,8'h01},
    '{4'h2,1'b1,3'h3,32'h0004_0000,13'h0020,3'h0,1'b1,4'h1,8'h00,dm,8'h00},
    '{4'h2,1'b1,3'h1,32'h0002_0000,13'h0020,3'h0,1'b1,4'h1,8'h00,dm,8'h00},
    '{4'h2,1'b1,3'h5,32'h0000_0001,13'h0020,3'h2,1'b1,4'h1,8'h00,dm,8'h01},
    '{4'h2,1'b1,3'h5,32'h0000_0002,13'h0020,3'h3,1'b1,4'h1,8'h00,dm,8'h01},
    '{4'h2,1'b1,3'h5,32'h0000_0004,13'h0020,3'h4,1'b1,4'h1,8'h00,dm,8'h01},
    '{4'h2,1'b1,3'h5,32'h0000_0008,13'h0020,3'h5,1'b1,4'h1,8'h00,dm,8'h01},
    '{4'h2,1'b1,3'h5,32'h0000_0400,13'h0020,3'h6,1'b1,4'h1,8'h00,dm,8'h01},
    '{4'h2,1'b1,3'h5,32'h0000_0400,13'h0020,3'h6,1'b1,4'h1,8'h00,dm_sz,8'h00},
    '{4'h1,1'b1,3'h0,32'h0000_0040,13'h0040,3'h7,1'b1,4'h1,8'h08,dm,8'h01},
    '{4'h1,1'b1,3'h0,32'h0000_0080,13'h0080,3'h7,1'b1,4'h1,8'h08,dm,8'h01},
    '{4'h1,1'b1,3'h0,32'h0000_0080,13'h0080,3'h7,1'b1,4'h1,8'h04,dm,8'h00},
    '{4'h1,1'b1,3'h0,32'h0000_0100,13'h0100,3'h7,1'b1,4'h1,8'h18,dm,8'h01},
    '{4'h1,1'b1,3'h0,32'h0000_0100,13'h0100,3'h7,1'b1,4'h1,8'h01,dm,8'h00},
    '{4'h1,1'b1,3'h1,32'h0000_0040,13'h0200,3'h7,1'b1,4'h1,8'h02,dm,8'h01},
    '{4'h1,1'b1,3'h1,32'h0000_0080,13'h0400,3'h7,1'b1,4'h1,8'h02,dm,8'h01},
    '{4'h1,1'b1,3'h1,32'h0000_0100,13'h0800,3'h7,1'b1,4'h1,8'h02,dm,8'h01},
    '{4'h1,1'b1,3'h1,32'h0000_0200,13'h1000,3'h7,1'b1,4'h1,8'h0f,dm,8'h01},
    '{4'h2,1'b1,3'h1,32'h0000_0040,13'h0200,3'h7,1'b1,4'h1,8'h02,dm,8'h00},
    '{4'h2,1'b1,3'h1,32'h0000_0600,13'h0018,3'h7,1'b1,4'h1,8'h00,dm,8'h02},
    '{4'h2,1'b1,3'h5,32'h0000_000f,13'h0020,3'h2,1'b1,4'h1,8'h00,dm,8'h01},
    '{4'h1,1'b1,3'h1,32'h0000_03c0,13'h1e00,3'h7,1'b1,4'h1,8'h02,dm,8'h04},
    '{4'h2,1'b1,3'h3,32'h0002_0000,13'h0020,3'h0,1'b1,4'h1,8'h00,dm_q,8'h00},
    '{4'h2,1'b1,3'h5,32'h0000_0001,13'h0020,3'h2,1'b1,4'h1,8'h00,dm_tc,8'h01},
    '{4'h2,1'b1,3'h5,32'h0000_0008,13'h0020,3'h5,1'b1,4'h1,8'h00,dm_id,8'h00},
    '{4'h1,1'b1,3'h1,32'h0000_0100,13'h0800,3'h7,1'b1,4'h1,8'h01,dm,8'h00}
  };

  ////////////////////////////////////////////////////////////////////////////
  // Device under test
  pes_counter #(.CW(32)) dut_u (
    .clk(clk), .arst_n(arst_n), .version_major(version_major), .cfg(cfg), .filt(filt),
    .count_clear(count_clear), .queue_write_dropped(qwd), .perm_bitmap_read(pbr),
    .perm_allowed(perm_allowed), .data_read(drd), .bytes_read_32b_units(units),
    .second_source_reads(s2r), .second_dest_writes(d2w), .op_done(opd), .op_kind(op_kind),
    .single_desc_ready(sdr), .group_desc_ready(gdr), .queue_empty(qem), .pipe_full(pfl),
    .nothing_ready(nrd), .group_fetch_full(gff), .group_exec_full(gef), .count(count)
  );

  // Clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive one cycle of the events a row selects, or idle them
  task automatic apply(input pes_row_t r, input logic on);
    pes_pkg::pes_desc_t d;
    d = r.d;
    d.valid = on;
    qwd <= r.ev[0] ? d : '0;
    pbr <= r.ev[1] ? d : '0;
    drd <= r.ev[2] ? d : '0;
    s2r <= r.ev[3] ? d : '0;
    d2w <= r.ev[4] ? d : '0;
    opd <= r.ev[5] ? d : '0;
    op_kind <= pes_pkg::pes_op_t'(r.kind);
    perm_allowed <= r.allow;
    units <= r.units;
    sdr <= (on && r.ev[6]) ? r.bv : 8'h00;
    gdr <= (on && r.ev[7]) ? r.bv : 8'h00;
    qem <= (on && r.ev[8]) ? r.bv : 8'h00;
    pfl <= (on && r.ev[9]) ? r.bv[3:0] : 4'h0;
    nrd <= (on && r.ev[10]) ? r.bv[3:0] : 4'h0;
    gff <= (on && r.ev[11]) ? r.bv[3:0] : 4'h0;
    gef <= (on && r.ev[12]) ? r.bv[3:0] : 4'h0;
  endtask : apply

  // Configure, clear, then present the events for n cycles
  task automatic run(input pes_row_t r, input int n);
    @(posedge clk);
    version_major <= r.ver;
    cfg <= '{r.en, r.cat, r.sel};
    count_clear <= 1'b1;
    @(posedge clk);
    count_clear <= 1'b0;
    repeat (n) begin
      apply(r, 1'b1);
      @(posedge clk);
    end
    apply(r, 1'b0);
    @(posedge clk);
    #1;
  endtask : run

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  // Verdict and end of run
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    version_major = 4'h0;
    cfg = '0;
    filt = '{8'h08, 4'h2, 1'b1, 20'h0_0abc, 8'h04, 4'h2};
    count_clear = 1'b0;
    apply(rows[0], 1'b0);
    repeat (12) @(posedge clk);
    #1;
    check(count, 32'h0000_0000);
    @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i], 1);
      check(count, {24'h00_0000, rows[i].exp});
    end
    // Cycle event held three cycles
    run(rows[31], 3);
    check(count, 32'h0000_0003);
    // Occurrences back to back
    run(rows[0], 4);
    check(count, 32'h0000_0004);
    // Clear in the cycle of a hit keeps that hit
    @(posedge clk);
    apply(rows[0], 1'b1);
    count_clear <= 1'b1;
    @(posedge clk);
    apply(rows[0], 1'b0);
    count_clear <= 1'b0;
    @(posedge clk);
    #1;
    check(count, 32'h0000_0001);
    // Id filter switched off lets a foreign id through
    @(posedge clk);
    filt.pasid_en <= 1'b0;
    run(rows[9], 1);
    check(count, 32'h0000_0001);
    // Reset in mid-run empties the count
    run(rows[0], 2);
    @(posedge clk);
    arst_n <= 1'b0;
    #5;
    check(count, 32'h0000_0000);
    @(posedge clk);
    arst_n <= 1'b1;
    run(rows[0], 1);
    check(count, 32'h0000_0001);
    final_report();
  end
endmodule : tb_perf_event_selector
